// ---- design/tcp_timer_block.sv ----
// Purpose: three 16-bit timers with capture and compare plus a two-channel pulse generator
// Assumes: byte accesses; a 16-bit count is read low byte then high byte within one latch
// Notes: pins are synchronised here; every request output is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_block #(
    // sizes; the byte-split register map serves only the defaults
    parameter int CNT_W   = 16,
    parameter int PULSE_W = 8,
    parameter int NPIN    = 3
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // cpu register access
    input  wire tcp_pkg::tcp_bus_s bus,
    output logic [7:0]          rdata,
    // external pins: capture a, capture b, event input
    input  wire logic           ext_edge_a,
    input  wire logic           ext_edge_b,
    input  wire logic           event_input,
    // interrupt requests
    output tcp_pkg::tcp_req_s   req,
    // port three low bits: pulse outputs and their function select
    output logic [1:0]          pulse_pin,
    output logic [1:0]          pulse_pin_sel
);
    // byte lanes, pin wiring and the three-bit prescaler only serve these values
    if (CNT_W != 16) begin : g_check_cnt_w
        $error("count width must be 16");
    end
    if (PULSE_W != 8) begin : g_check_pulse_w
        $error("pulse counter width must be 8");
    end
    if (NPIN != 3) begin : g_check_npin
        $error("exactly three pins are synchronised");
    end
    if (tcp_pkg::DIV_FREE != 8 || tcp_pkg::DIV_FOUR != 4 || tcp_pkg::DIV_PULSE != 2) begin : g_check_div
        $error("prescale counts do not fit the three-bit prescaler");
    end

    logic [CNT_W-1:0]   free_run_count_q;
    logic [CNT_W-1:0]   event_count_q;
    logic [CNT_W-1:0]   interval_count_q;
    logic [CNT_W-1:0]   capture_reg_a_q;
    logic [CNT_W-1:0]   capture_reg_b_q;
    logic [CNT_W-1:0]   interval_compare_one_q;
    logic [CNT_W-1:0]   interval_compare_two_q;
    logic [7:0]         counter_control_a_q;
    logic [7:0]         counter_control_b_q;
    logic [7:0]         edge_select_a_q;
    logic [7:0]         edge_select_b_q;
    logic [7:0]         pin_function_select_q;
    logic [7:0]         pulse_control_q;
    logic [7:0]         pulse_buffer_a_q;
    logic [7:0]         pulse_buffer_b_q;
    logic [PULSE_W-1:0] pulse_compare_a_q;
    logic [PULSE_W-1:0] pulse_compare_b_q;
    logic [PULSE_W-1:0] pulse_count_q;
    logic [2:0]         pre_q;
    logic [7:0]         rd_high_q;
    logic [1:0]         pulse_lvl_q;
    tcp_pkg::tcp_req_s  req_q;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] sync3_q;
    logic [NPIN-1:0] edge_hit;
    assign pin_raw = {event_input, ext_edge_b, ext_edge_a};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_edge
            logic [1:0] mode;
            assign mode = edge_select_a_q[2*gi +: 2];
            assign edge_hit[gi] = (mode[0] && sync2_q[gi] && !sync3_q[gi])
                               || (mode[1] && !sync2_q[gi] && sync3_q[gi]);
        end
    endgenerate

    // shared prescaler ticks
    logic tick2;
    logic tick4;
    logic tick8;
    always_ff @(posedge clk) begin
        if (!rst_n) pre_q <= 3'h0;
        else        pre_q <= pre_q + 3'h1;
    end
    assign tick2 = pre_q[0];
    assign tick4 = &pre_q[1:0];
    assign tick8 = &pre_q;

    // cpu writes
    logic wr_hit;
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        hit = bus.wr && (bus.addr == a) && (a == base);
    endfunction
    assign wr_hit = bus.wr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counter_control_a_q   <= tcp_pkg::RST_CTRL;
            counter_control_b_q   <= tcp_pkg::RST_CTRL;
            edge_select_a_q       <= tcp_pkg::RST_CTRL;
            edge_select_b_q       <= tcp_pkg::RST_CTRL;
            pin_function_select_q <= tcp_pkg::RST_CTRL;
            pulse_control_q       <= tcp_pkg::RST_CTRL;
        end else if (wr_hit) begin
            case (bus.addr)
                tcp_pkg::ADDR_CTRL_A:     counter_control_a_q   <= bus.wdata;
                tcp_pkg::ADDR_CTRL_B:     counter_control_b_q   <= bus.wdata;
                tcp_pkg::ADDR_EDGE_A:     edge_select_a_q       <= bus.wdata;
                tcp_pkg::ADDR_EDGE_B:     edge_select_b_q       <= bus.wdata;
                tcp_pkg::ADDR_PIN_FUNC:   pin_function_select_q <= bus.wdata;
                tcp_pkg::ADDR_PULSE_CTRL: pulse_control_q       <= bus.wdata;
                default: ;
            endcase
        end
    end

    // compare and buffer registers: undefined after reset, held at zero here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interval_compare_one_q <= tcp_pkg::RST_COUNT;
            interval_compare_two_q <= tcp_pkg::RST_COUNT;
            pulse_buffer_a_q       <= tcp_pkg::RST_CTRL;
            pulse_buffer_b_q       <= tcp_pkg::RST_CTRL;
        end else if (wr_hit) begin
            case (bus.addr)
                tcp_pkg::ADDR_CMP_ONE:          interval_compare_one_q[7:0]  <= bus.wdata;
                tcp_pkg::ADDR_CMP_ONE + 16'h1:  interval_compare_one_q[15:8] <= bus.wdata;
                tcp_pkg::ADDR_CMP_TWO:          interval_compare_two_q[7:0]  <= bus.wdata;
                tcp_pkg::ADDR_CMP_TWO + 16'h1:  interval_compare_two_q[15:8] <= bus.wdata;
                tcp_pkg::ADDR_PULSE_BUF_A:      pulse_buffer_a_q             <= bus.wdata;
                tcp_pkg::ADDR_PULSE_BUF_B:      pulse_buffer_b_q             <= bus.wdata;
                default: ;
            endcase
        end
    end

    logic free_wrap;
    assign free_wrap = counter_control_a_q[tcp_pkg::CA_FREE_RUN] && tick8 && (&free_run_count_q);
    always_ff @(posedge clk) begin
        if (!rst_n)
            free_run_count_q <= tcp_pkg::RST_COUNT;
        else if (counter_control_a_q[tcp_pkg::CA_FREE_RUN] && tick8)
            free_run_count_q <= free_run_count_q + 16'h1;
    end

    // capture on edge, capture enable bits gate it; a cpu write loses to a capture
    logic cap_a;
    logic cap_b;
    assign cap_a = edge_hit[0] && counter_control_b_q[tcp_pkg::CB_CAP_A_EN];
    assign cap_b = edge_hit[1] && counter_control_b_q[tcp_pkg::CB_CAP_B_EN];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capture_reg_a_q <= tcp_pkg::RST_COUNT;
            capture_reg_b_q <= tcp_pkg::RST_COUNT;
        end else begin
            if (cap_a)
                capture_reg_a_q <= free_run_count_q;
            else if (hit(bus.addr, tcp_pkg::ADDR_CAP_A))
                capture_reg_a_q[7:0] <= bus.wdata;
            else if (hit(bus.addr, tcp_pkg::ADDR_CAP_A + 16'h1))
                capture_reg_a_q[15:8] <= bus.wdata;
            if (cap_b)
                capture_reg_b_q <= free_run_count_q;
            else if (hit(bus.addr, tcp_pkg::ADDR_CAP_B))
                capture_reg_b_q[7:0] <= bus.wdata;
            else if (hit(bus.addr, tcp_pkg::ADDR_CAP_B + 16'h1))
                capture_reg_b_q[15:8] <= bus.wdata;
        end
    end

    logic ev_step;
    logic ev_match;
    assign ev_step = counter_control_a_q[tcp_pkg::CA_EVENT_RUN]
                  && (counter_control_a_q[tcp_pkg::CA_EVENT_SRC] ? edge_hit[2] : tick8);
    assign ev_match = ev_step && (event_count_q == interval_compare_one_q);
    always_ff @(posedge clk) begin
        if (!rst_n)
            event_count_q <= tcp_pkg::RST_COUNT;
        else if (!counter_control_a_q[tcp_pkg::CA_EVENT_RUN])
            event_count_q <= tcp_pkg::RST_COUNT;
        else if (ev_match)
            event_count_q <= tcp_pkg::RST_COUNT;
        else if (ev_step)
            event_count_q <= event_count_q + 16'h1;
    end

    logic iv_step;
    logic iv_match;
    assign iv_step = counter_control_a_q[tcp_pkg::CA_INTV_RUN]
                  && (counter_control_a_q[tcp_pkg::CA_INTV_DIV8] ? tick8 : tick4);
    assign iv_match = iv_step && (interval_count_q == interval_compare_two_q);
    always_ff @(posedge clk) begin
        if (!rst_n)
            interval_count_q <= tcp_pkg::RST_COUNT;
        else if (!counter_control_a_q[tcp_pkg::CA_INTV_RUN])
            interval_count_q <= tcp_pkg::RST_COUNT;
        else if (iv_match)
            interval_count_q <= tcp_pkg::RST_COUNT;
        else if (iv_step)
            interval_count_q <= interval_count_q + 16'h1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            req_q.overflow_request  <= free_wrap;
            req_q.match_request_one <= ev_match;
            req_q.match_request_two <= iv_match;
            req_q.edge_req_a <= edge_hit[0] && edge_select_b_q[tcp_pkg::EB_REQ_A];
            req_q.edge_req_b <= edge_hit[1] && edge_select_b_q[tcp_pkg::EB_REQ_B];
        end
    end
    assign req = req_q;

    logic pulse_run;
    logic pulse_ovf;
    assign pulse_run = pulse_control_q[tcp_pkg::PC_RUN];
    assign pulse_ovf = pulse_run && tick2 && (&pulse_count_q);
    always_ff @(posedge clk) begin
        if (!rst_n)
            pulse_count_q <= 8'h00;
        else if (pulse_run && tick2)
            pulse_count_q <= pulse_count_q + 8'h01;
    end

    // reload compares and go active on overflow
    // go inactive on match; overflow wins if both occur together
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_compare_a_q <= 8'h00;
            pulse_compare_b_q <= 8'h00;
            pulse_lvl_q       <= 2'b00;
        end else if (pulse_ovf) begin
            pulse_compare_a_q <= pulse_buffer_a_q;
            pulse_compare_b_q <= pulse_buffer_b_q;
            pulse_lvl_q       <= 2'b11;
        end else if (pulse_run && tick2) begin
            if (pulse_count_q + 8'h01 == pulse_compare_a_q)
                pulse_lvl_q[0] <= 1'b0;
            if (pulse_count_q + 8'h01 == pulse_compare_b_q)
                pulse_lvl_q[1] <= 1'b0;
        end
    end

    // polarity; set bit means active low
    logic [1:0] pol;
    logic [1:0] pin_q;
    assign pol = {pulse_control_q[tcp_pkg::PC_POL_B], pulse_control_q[tcp_pkg::PC_POL_A]};
    always_ff @(posedge clk) begin
        if (!rst_n) pin_q <= 2'b00;
        else        pin_q <= pulse_lvl_q ^ pol;
    end
    assign pulse_pin_sel = {pin_function_select_q[tcp_pkg::PF_PULSE_B],
                            pin_function_select_q[tcp_pkg::PF_PULSE_A]};
    assign pulse_pin = pin_q & pulse_pin_sel;

    // counts read-only; low byte read latches high byte for a coherent word
    logic [15:0] cnt_sel;
    always_comb begin
        cnt_sel = 16'h0000;
        case (bus.addr)
            tcp_pkg::ADDR_FREE_CNT:  cnt_sel = free_run_count_q;
            tcp_pkg::ADDR_EVENT_CNT: cnt_sel = event_count_q;
            tcp_pkg::ADDR_INTV_CNT:  cnt_sel = interval_count_q;
            default: ;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n)       rd_high_q <= 8'h00;
        else if (bus.rd)  rd_high_q <= cnt_sel[15:8];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                tcp_pkg::ADDR_CAP_A:               rdata <= capture_reg_a_q[7:0];
                tcp_pkg::ADDR_CAP_A + 16'h1:       rdata <= capture_reg_a_q[15:8];
                tcp_pkg::ADDR_CAP_B:               rdata <= capture_reg_b_q[7:0];
                tcp_pkg::ADDR_CAP_B + 16'h1:       rdata <= capture_reg_b_q[15:8];
                tcp_pkg::ADDR_CMP_ONE:             rdata <= interval_compare_one_q[7:0];
                tcp_pkg::ADDR_CMP_ONE + 16'h1:     rdata <= interval_compare_one_q[15:8];
                tcp_pkg::ADDR_CMP_TWO:             rdata <= interval_compare_two_q[7:0];
                tcp_pkg::ADDR_CMP_TWO + 16'h1:     rdata <= interval_compare_two_q[15:8];
                tcp_pkg::ADDR_FREE_CNT,
                tcp_pkg::ADDR_EVENT_CNT,
                tcp_pkg::ADDR_INTV_CNT:            rdata <= cnt_sel[7:0];
                tcp_pkg::ADDR_FREE_CNT + 16'h1,
                tcp_pkg::ADDR_EVENT_CNT + 16'h1,
                tcp_pkg::ADDR_INTV_CNT + 16'h1:    rdata <= rd_high_q;
                tcp_pkg::ADDR_CTRL_A:              rdata <= counter_control_a_q;
                tcp_pkg::ADDR_CTRL_B:              rdata <= counter_control_b_q;
                tcp_pkg::ADDR_EDGE_A:              rdata <= edge_select_a_q;
                tcp_pkg::ADDR_EDGE_B:              rdata <= edge_select_b_q;
                tcp_pkg::ADDR_PIN_FUNC:            rdata <= pin_function_select_q;
                tcp_pkg::ADDR_PULSE_CTRL:          rdata <= pulse_control_q;
                tcp_pkg::ADDR_PULSE_BUF_A:         rdata <= pulse_buffer_a_q;
                tcp_pkg::ADDR_PULSE_BUF_B:         rdata <= pulse_buffer_b_q;
                default:                           rdata <= 8'h00;
            endcase
        end
    end
endmodule : tcp_timer_block
`default_nettype wire

// ---- design/tcp_pkg.sv ----
// Purpose: shared constants and types for the timer, capture, compare and pulse block
// Assumes: byte-wide cpu access at the special register addresses, words split in two bytes
// Notes: field layouts of the control registers are local choices
package tcp_pkg;
    // register addresses
    localparam logic [15:0] ADDR_CAP_A      = 16'hff10;
    localparam logic [15:0] ADDR_CAP_B      = 16'hff12;
    localparam logic [15:0] ADDR_CMP_ONE    = 16'hff14;
    localparam logic [15:0] ADDR_CMP_TWO    = 16'hff1e;
    localparam logic [15:0] ADDR_FREE_CNT   = 16'hff30;
    localparam logic [15:0] ADDR_EVENT_CNT  = 16'hff32;
    localparam logic [15:0] ADDR_INTV_CNT   = 16'hff34;
    localparam logic [15:0] ADDR_CTRL_A     = 16'hff38;
    localparam logic [15:0] ADDR_CTRL_B     = 16'hff39;
    localparam logic [15:0] ADDR_EDGE_A     = 16'hff3c;
    localparam logic [15:0] ADDR_EDGE_B     = 16'hff3d;
    localparam logic [15:0] ADDR_PIN_FUNC   = 16'hff43;
    localparam logic [15:0] ADDR_PULSE_CTRL = 16'hff64;
    localparam logic [15:0] ADDR_PULSE_BUF_A = 16'hff66;
    localparam logic [15:0] ADDR_PULSE_BUF_B = 16'hff6e;

    // reset values
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0]  RST_CTRL  = 8'h00;

    // counter_control_a fields
    localparam int CA_FREE_RUN = 0;
    localparam int CA_EVENT_RUN = 1;
    localparam int CA_EVENT_SRC = 2;
    localparam int CA_INTV_RUN = 4;
    localparam int CA_INTV_DIV8 = 5;
    // counter_control_b fields
    localparam int CB_CAP_A_EN = 0;
    localparam int CB_CAP_B_EN = 1;
    // edge_select_a fields: two bits per pin, pin index i at 2*i
    localparam int ES_EDGE_A = 0;
    localparam int ES_EDGE_B = 2;
    localparam int ES_EVENT  = 4;
    // edge_select_b fields: interrupt enables of the two capture pins
    localparam int EB_REQ_A = 0;
    localparam int EB_REQ_B = 1;
    // pulse_control fields
    localparam int PC_RUN   = 0;
    localparam int PC_POL_A = 1;
    localparam int PC_POL_B = 2;
    // pin_function_select bits carrying the pulse outputs
    localparam int PF_PULSE_A = 0;
    localparam int PF_PULSE_B = 1;

    // prescale counts in system clocks
    localparam int DIV_FREE  = 8;
    localparam int DIV_FOUR  = 4;
    localparam int DIV_PULSE = 2;

    // edge modes
    typedef enum logic [1:0] {
        TCP_EDGE_NONE = 2'b00,
        TCP_EDGE_RISE = 2'b01,
        TCP_EDGE_FALL = 2'b10,
        TCP_EDGE_BOTH = 2'b11
    } tcp_edge_e;

    // cpu access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tcp_bus_s;

    // interrupt request pulses
    typedef struct packed {
        logic overflow_request;
        logic match_request_one;
        logic match_request_two;
        logic edge_req_a;
        logic edge_req_b;
    } tcp_req_s;
endpackage : tcp_pkg

// ---- dv/tcp_monitor.sv ----
// Purpose: port checks for the timer, capture and pulse block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the design from the bench top file
`timescale 1ns/100ps
`default_nettype none
module tcp_monitor (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // cpu side
    input wire tcp_pkg::tcp_bus_s bus,
    input wire logic [7:0]        rdata,
    // pins and requests
    input wire logic              ext_edge_a,
    input wire logic              ext_edge_b,
    input wire logic              event_input,
    input wire tcp_pkg::tcp_req_s req,
    input wire logic [1:0]        pulse_pin,
    input wire logic [1:0]        pulse_pin_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rst_quiet_a: assert property ($rose(rst_n) |-> rdata == 8'h00 && req == '0 && pulse_pin == 2'b00)
        else $error("outputs not quiet after reset");
    ovf_single_a: assert property (req.overflow_request |=> !req.overflow_request [*8])
        else $error("overflow request not a lone pulse");
    match_one_a: assert property (req.match_request_one |=> !req.match_request_one)
        else $error("event match request longer than one cycle");
    match_two_a: assert property (req.match_request_two |=> !req.match_request_two [*3])
        else $error("interval match requests too close");
    // a request must trace back to a pin change two to five clocks earlier
    edge_sync_a: assert property (req.edge_req_a |-> !($past(ext_edge_a, 2) == $past(ext_edge_a, 3)
        && $past(ext_edge_a, 3) == $past(ext_edge_a, 4) && $past(ext_edge_a, 4) == $past(ext_edge_a, 5)))
        else $error("edge request without a pin change");
    pin_mask_a: assert property ((pulse_pin & ~pulse_pin_sel) == 2'b00)
        else $error("pulse output on an unselected pin");
    sel_write_a: assert property (bus.wr && bus.addr == tcp_pkg::ADDR_PIN_FUNC |=>
        pulse_pin_sel == $past(bus.wdata[1:0])) else $error("pin function select not updated");
    rdata_hold_a: assert property (!$past(bus.rd) |-> $stable(rdata))
        else $error("read data moved without a read");
endmodule : tcp_monitor
`default_nettype wire

// ---- dv/tcp_pin_model.sv ----
// Purpose: far-side model driving the capture, capture and event pins
// Assumes: the bench spaces flips by several clocks
// Notes: levels only change on a flip request
`timescale 1ns/100ps
`default_nettype none
module tcp_pin_model (
    // clock
    input wire logic  clk,
    // one-cycle flip requests: a, b, event
    input wire logic [2:0] flip,
    // pin levels
    output logic [2:0]     pins
);
    initial pins = 3'b000;
    always @(posedge clk) begin
        pins <= pins ^ flip;
    end
endmodule : tcp_pin_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the timer, capture and pulse block
// Assumes: byte register access, counts within small tolerances of prescale phase
// Notes: expected values come from cycle counts and programmed values
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic              clk;
    logic              rst_n;
    tcp_pkg::tcp_bus_s bus;
    logic [7:0]        rdata;
    logic [7:0]        b;
    logic [15:0]       w;
    tcp_pkg::tcp_req_s req;
    logic [1:0]        pulse_pin;
    logic [1:0]        pulse_pin_sel;
    logic [2:0]        flip;
    logic [2:0]        pins;
    int                fails, compares, seed, cyc, n_ea, n_eb, n_m1, n_m2, hi, lo, v, t0, k;

    tcp_timer_block i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .ext_edge_a(pins[0]),
        .ext_edge_b(pins[1]), .event_input(pins[2]), .req(req), .pulse_pin(pulse_pin),
        .pulse_pin_sel(pulse_pin_sel));
    tcp_pin_model i_pins (.clk(clk), .flip(flip), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_ea <= n_ea + int'(req.edge_req_a === 1'b1);
        n_eb <= n_eb + int'(req.edge_req_b === 1'b1);
        n_m1 <= n_m1 + int'(req.match_request_one === 1'b1);
        n_m2 <= n_m2 + int'(req.match_request_two === 1'b1);
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t byte %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_near(input logic [15:0] got, input int exp, input int tol);
        compares++;
        if ((^got) === 1'bx || int'(got) < exp - tol || int'(got) > exp + tol) begin
            fails++;
            $display("Error %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_near

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : bus_rd

    // low byte first so the high byte comes from the same latch
    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        bus_rd(a, d[7:0]);
        bus_rd(a + 16'h0001, d[15:8]);
    endtask : rd16

    task automatic toggle(input logic [2:0] mask);
        @(posedge clk);
        flip <= mask;
        @(posedge clk);
        flip <= 3'b000;
        // a pin flip reaches the request counters four clocks after the model applies it
        repeat (5) @(posedge clk);
    endtask : toggle

    task automatic complete_run;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    initial begin
        #(100 * 60000);
        fails++;
        $display("Error %0t run too long", $time);
        complete_run;
    end

    initial begin
        {bus, flip, rst_n} = '0;
        {fails, compares, cyc, n_ea, n_eb, n_m1, n_m2} = '0;
        seed = 45437;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus_wr(tcp_pkg::ADDR_INTV_CNT, 8'h5a);
        for (int i = 0; i < 3; i++) begin
            rd16(tcp_pkg::ADDR_FREE_CNT + 16'(2 * i), w);
            cmp_near(w, 0, 0);
        end
        bus_rd(16'hff50, b);
        cmp_byte(b, 8'h00);
        bus_wr(tcp_pkg::ADDR_CTRL_B, 8'h03);
        bus_wr(tcp_pkg::ADDR_EDGE_B, 8'h03);
        bus_wr(tcp_pkg::ADDR_CTRL_A, 8'h01);
        t0 = cyc;
        for (int m = 0; m < 4; m++) begin
            // both capture pins get the same mode and flip together
            bus_wr(tcp_pkg::ADDR_EDGE_A, 8'(m * 5));
            hi = n_ea;
            lo = n_eb;
            v = cyc;
            toggle(3'b011);
            toggle(3'b011);
            cmp_near(16'(n_ea - hi), m % 2 + m / 2, 0);
            cmp_near(16'(n_eb - lo), m % 2 + m / 2, 0);
            if (m == 1) begin
                rd16(tcp_pkg::ADDR_CAP_A, w);
                cmp_near(w, (v + 4 - t0) / 8, 2);
                rd16(tcp_pkg::ADDR_CAP_B, w);
                cmp_near(w, (v + 4 - t0) / 8, 2);
            end
        end
        rd16(tcp_pkg::ADDR_FREE_CNT, w);
        cmp_near(w, (cyc - t0) / 8, 2);
        k = 1 + int'($unsigned($random(seed)) % 4);
        bus_wr(tcp_pkg::ADDR_CMP_ONE, 8'(k));
        bus_wr(tcp_pkg::ADDR_CMP_ONE + 16'h0001, 8'h00);
        bus_wr(tcp_pkg::ADDR_EDGE_A, 8'h10);
        bus_wr(tcp_pkg::ADDR_CTRL_A, 8'h07);
        hi = n_m1;
        repeat (2 * k + 4) toggle(3'b100);
        cmp_near(16'(n_m1 - hi), 1, 0);
        rd16(tcp_pkg::ADDR_EVENT_CNT, w);
        cmp_near(w, 1, 0);
        // divided clock as source; the count left over only shifts the first match
        bus_wr(tcp_pkg::ADDR_CTRL_A, 8'h02);
        hi = n_m1;
        repeat (400) @(posedge clk);
        cmp_near(16'(n_m1 - hi), 400 / (8 * (k + 1)), 1);
        k = int'($unsigned($random(seed)) % 8);
        bus_wr(tcp_pkg::ADDR_CMP_TWO, 8'(k));
        bus_wr(tcp_pkg::ADDR_CMP_TWO + 16'h0001, 8'h00);
        for (int d = 0; d < 2; d++) begin
            bus_wr(tcp_pkg::ADDR_CTRL_A, d == 1 ? 8'h30 : 8'h10);
            hi = n_m2;
            repeat (800) @(posedge clk);
            cmp_near(16'(n_m2 - hi), 800 / ((4 + 4 * d) * (k + 1)), 1);
        end
        v = 16 + int'($unsigned($random(seed)) % 224);
        k = 16 + int'($unsigned($random(seed)) % 224);
        bus_wr(tcp_pkg::ADDR_PULSE_BUF_A, 8'(v));
        bus_wr(tcp_pkg::ADDR_PULSE_BUF_B, 8'(k));
        bus_wr(tcp_pkg::ADDR_PIN_FUNC, 8'h03);
        bus_wr(tcp_pkg::ADDR_PULSE_CTRL, 8'h05);
        repeat (1100) @(posedge clk);
        hi = 0;
        lo = 0;
        repeat (512) begin
            @(posedge clk);
            hi += int'(pulse_pin[0] === 1'b1);
            lo += int'(pulse_pin[1] === 1'b0);
        end
        cmp_near(16'(hi), 2 * v, 3);
        cmp_near(16'(lo), 2 * k, 3);
        bus_wr(tcp_pkg::ADDR_PIN_FUNC, 8'h00);
        repeat (600) @(posedge clk);
        cmp_byte({6'h00, pulse_pin}, 8'h00);
        complete_run;
    end
endmodule : testbench

bind tcp_timer_block tcp_monitor i_mon (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ext_edge_a(ext_edge_a), .ext_edge_b(ext_edge_b), .event_input(event_input), .req(req),
    .pulse_pin(pulse_pin), .pulse_pin_sel(pulse_pin_sel));
`default_nettype wire
